// File: design/kscan_pkg.sv
// constants, register map and state codes of the key matrix scanner
// assumes one 20 MHz clock and an axi4-lite register port with 12 address bits
package kscan_pkg;

	// matrix geometry: five drive rows, eight sense columns, one 32-bit word per row
	localparam int NUM_ROWS = 5;
	localparam int NUM_COLS = 8;
	localparam int ROW_WORD = 32;
	localparam int NUM_KEYS = NUM_ROWS * NUM_COLS;
	localparam logic [2:0] MAX_REPORTED_KEYS = 3'h6;
	localparam logic [2:0] RELEASE_HOLD = 3'h6;
	localparam logic [2:0] LAST_ROW = 3'(NUM_ROWS);
	localparam logic [5:0] KEY_IDX_END = 6'(NUM_KEYS);

	// settle delay after each change of the row drive
	localparam int CLK_MHZ = 20;
	localparam int SETTLE_US = 20;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam logic [8:0] SETTLE_LOAD = 9'(SETTLE_CYC - 1);

	// modifier keycode window of a hid keyboard
	localparam logic [7:0] MOD_CODE_LO = 8'he0;
	localparam logic [7:0] MOD_CODE_HI = 8'he7;

	// register byte addresses
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_EVT_LO = 12'h008;
	localparam logic [11:0] OFF_EVT_HI = 12'h00c;
	localparam logic [11:0] OFF_MATRIX = 12'h010;
	localparam logic [11:0] OFF_MATRIX_END = 12'h024;
	localparam logic [11:0] OFF_KEYMAP = 12'h100;
	localparam logic [11:0] OFF_KEYMAP_END = 12'h1a0;

	// control and status bit positions
	localparam int CTRL_START = 0;
	localparam int CTRL_FAST = 1;
	localparam int CTRL_DELIVER = 2;
	localparam int STAT_BUSY = 0;
	localparam int STAT_UPDATE = 1;
	localparam int STAT_PENDING = 2;

	localparam logic CTRL_FAST_RESET = 1'h0;
	localparam logic CTRL_DELIVER_RESET = 1'h1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_PROBE = 3'b001,
		ST_ROWS = 3'b010,
		ST_FILTER = 3'b011,
		ST_LOOKUP = 3'b100,
		ST_DONE = 3'b101
	} kscan_state_e;

endpackage

// File: design/kscan_keymap.sv
// keymap memory: one keycode byte per matrix position, row-major
// assumes writes from the register port and reads from the lookup walk
`timescale 1ns/1ns
module kscan_keymap
	import kscan_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire logic [5:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [5:0] rd_addr,
	output logic [7:0] rd_data
);

	logic [7:0] table_mem [NUM_KEYS];

	// table contents carry no reset; software loads them before the first scan
	always_ff @(posedge aclk)
	begin
		if (wr_en)
			table_mem[wr_addr] <= wr_data;
	end

	// registered read, one cycle of latency
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rd_data <= 8'h00;
		else if (rd_addr < KEY_IDX_END)
			rd_data <= table_mem[rd_addr];
		else
			rd_data <= 8'h00;
	end

endmodule // kscan_keymap

// File: design/kscan_top.sv
// key matrix scanner: probes a row/column switch matrix, debounces it and
// builds an 8-byte event record through the keymap memory.
// assumes sense columns pulled up outside, rows driven low when active,
// one 20 MHz clock with synchronous active-low reset, axi4-lite registers.
//
// What this block does
// - every pass reports one update bit: 1 when a change is delivered, else 0
// - filtered change needs two equal scans differing from stored state, then stored
// - after reset the stored state is all released and filtering is on
// - event record is count byte, modifier byte and six keycode bytes
// - beyond six pressed keys only the first six found are recorded
// - count clears at each pass start; keycode bytes keep old contents
// - update with count zero means a release; keycodes then meaningless
// - update with count n holds the pressed codes in the first n bytes
// - pass starts with all rows active, records column mask, ends if empty once the release hold has run out
// - wait about 20 us after each row drive change before sampling
// - row scanning continues until seven successive probes find nothing pressed
// - on activity rows are driven in turn, only masked columns sampled
// - row scan pipelined: each capture moves the drive on, the last row's capture ends the walk
// - raw state is one 32-bit word per row, bit n is column n
// - fast wake option bypasses filtering so the first scan reports
// - state is buffered; delivered now, or held until deliver-now returns
// - each pressed position is translated through the row-by-column keymap
// - columns idle high; active row low; low column means key pressed
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module kscan_top
	import kscan_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_COLS-1:0] col_level,
	output logic [NUM_ROWS-1:0] row_level,
	output logic scan_done,
	output logic scan_update,
	output logic [63:0] key_event_record
);

	kscan_state_e state;
	logic [NUM_COLS-1:0] col_meta;
	logic [NUM_COLS-1:0] col_sync;
	logic [NUM_COLS-1:0] col_need;
	logic [NUM_COLS-1:0] col_low;
	logic [8:0] settle_cnt;
	logic [2:0] release_cnt;
	logic [2:0] step;
	logic [ROW_WORD-1:0] scan_mx [NUM_ROWS];
	logic [ROW_WORD-1:0] prev_mx [NUM_ROWS];
	logic [ROW_WORD-1:0] stored_mx [NUM_ROWS];
	logic [ROW_WORD-1:0] deliv_mx [NUM_ROWS];
	logic [NUM_KEYS-1:0] deliv_flat;
	logic pending;
	logic delivered;
	logic fast_wake_scan_option;
	logic deliver_now;
	logic update_seen;
	logic changed;
	logic start_pulse;
	logic aw_take;
	logic ar_take;
	logic wr_ctrl;
	logic wr_map_hit;
	logic wr_ok;
	logic [11:0] wr_map_off;
	logic [11:0] rd_mx_off;
	logic [31:0] rd_word;
	logic rd_ok;
	logic [5:0] lk_idx;
	logic lk_valid;
	logic lk_hit;
	logic lk_done;
	logic [7:0] map_code;
	logic [2:0] rec_cnt;
	logic [7:0] rec_mod;
	logic [7:0] rec_codes [MAX_REPORTED_KEYS];

	// two-stage synchroniser on the sense pins; only col_sync is read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			col_meta <= '1;
			col_sync <= '1;
		end
		else
		begin
			col_meta <= col_level;
			col_sync <= col_meta;
		end
	end

	// a low column under an active row marks a press
	assign col_low = ~col_sync;

	// axi write: address and data taken together, so either order works
	assign aw_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	assign wr_map_off = s_axi_awaddr - OFF_KEYMAP;
	assign wr_map_hit = (s_axi_awaddr >= OFF_KEYMAP) && (s_axi_awaddr < OFF_KEYMAP_END);
	assign wr_ctrl = s_axi_awready && (s_axi_awaddr[11:2] == OFF_CTRL[11:2]) && s_axi_wstrb[0];
	assign wr_ok = (s_axi_awaddr[11:2] == OFF_CTRL[11:2]) || wr_map_hit
		|| (s_axi_awaddr[11:2] == OFF_STATUS[11:2])
		|| (s_axi_awaddr[11:2] == OFF_EVT_LO[11:2])
		|| (s_axi_awaddr[11:2] == OFF_EVT_HI[11:2])
		|| ((s_axi_awaddr >= OFF_MATRIX) && (s_axi_awaddr < OFF_MATRIX_END));
	assign start_pulse = wr_ctrl && s_axi_wdata[CTRL_START];

	// handshake and response of the write channels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= aw_take;
			s_axi_wready <= aw_take;
			if (s_axi_awready)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// control bits; filtering on and delivery immediate after reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fast_wake_scan_option <= CTRL_FAST_RESET;
			deliver_now <= CTRL_DELIVER_RESET;
		end
		else if (wr_ctrl)
		begin
			fast_wake_scan_option <= s_axi_wdata[CTRL_FAST];
			deliver_now <= s_axi_wdata[CTRL_DELIVER];
		end
	end

	// read data mux; keymap is write-only so its reads return zero
	assign rd_mx_off = s_axi_araddr - OFF_MATRIX;
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		if (s_axi_araddr[11:2] == OFF_CTRL[11:2])
		begin
			rd_word[CTRL_FAST] = fast_wake_scan_option;
			rd_word[CTRL_DELIVER] = deliver_now;
		end
		else if (s_axi_araddr[11:2] == OFF_STATUS[11:2])
		begin
			rd_word[STAT_BUSY] = (state != ST_IDLE);
			rd_word[STAT_UPDATE] = update_seen;
			rd_word[STAT_PENDING] = pending;
		end
		else if (s_axi_araddr[11:2] == OFF_EVT_LO[11:2])
			rd_word = key_event_record[31:0];
		else if (s_axi_araddr[11:2] == OFF_EVT_HI[11:2])
			rd_word = key_event_record[63:32];
		else if ((s_axi_araddr >= OFF_MATRIX) && (s_axi_araddr < OFF_MATRIX_END))
			rd_word = stored_mx[rd_mx_off[4:2]];
		else if (!((s_axi_araddr >= OFF_KEYMAP) && (s_axi_araddr < OFF_KEYMAP_END)))
			rd_ok = 1'b0;
	end

	// read channel: one read at a time, data one cycle after acceptance
	assign ar_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= ar_take;
			if (s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// filter decision: fast wake reports the first scan, else two equal scans
	always_comb
	begin
		if (fast_wake_scan_option)
			changed = (scan_mx != stored_mx);
		else
			changed = (scan_mx == prev_mx) && (scan_mx != stored_mx);
	end

	// scan sequencer: probe, row walk, filter, buffer, hand over to lookup
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= ST_IDLE;
			row_level <= '1;
			settle_cnt <= 9'h000;
			col_need <= '0;
			release_cnt <= 3'h0;
			step <= 3'h0;
			pending <= 1'b0;
			delivered <= 1'b0;
			scan_done <= 1'b0;
			scan_update <= 1'b0;
			for (int r = 0; r < NUM_ROWS; r++)
			begin
				scan_mx[r] <= '0;
				prev_mx[r] <= '0;
				stored_mx[r] <= '0;
				deliv_mx[r] <= '0;
			end
		end
		else
		begin
			scan_done <= 1'b0;
			scan_update <= 1'b0;
			unique case (state)
				ST_IDLE:
				begin
					row_level <= '1;
					delivered <= 1'b0;
					if (start_pulse)
					begin
						state <= ST_PROBE;
						row_level <= '0;
						settle_cnt <= SETTLE_LOAD;
					end
					else if (pending && deliver_now)
					begin
						pending <= 1'b0;
						delivered <= 1'b1;
						state <= ST_LOOKUP;
					end
				end
				ST_PROBE:
				begin
					if (settle_cnt != 9'h000)
						settle_cnt <= settle_cnt - 9'h001;
					else if ((col_low != '0) || (release_cnt != 3'h0))
					begin
						// a release keeps the row walk alive for several probes
						if (col_low != '0)
							release_cnt <= RELEASE_HOLD;
						else
							release_cnt <= release_cnt - 3'h1;
						col_need <= col_low;
						state <= ST_ROWS;
						row_level <= ~NUM_ROWS'(1);
						step <= 3'h1;
						settle_cnt <= SETTLE_LOAD;
					end
					else
					begin
						// nothing pressed and hold expired: end early, no update
						row_level <= '1;
						state <= ST_DONE;
					end
				end
				ST_ROWS:
				begin
					if (settle_cnt != 9'h000)
						settle_cnt <= settle_cnt - 9'h001;
					else
					begin
						// capture the settled row, then move the drive on
						scan_mx[step - 3'h1] <= ROW_WORD'(col_low & col_need);
						settle_cnt <= SETTLE_LOAD;
						if (step == LAST_ROW)
						begin
							row_level <= '1;
							state <= ST_FILTER;
						end
						else
						begin
							row_level <= ~(NUM_ROWS'(1) << step);
							step <= step + 3'h1;
						end
					end
				end
				ST_FILTER:
				begin
					prev_mx <= scan_mx;
					state <= ST_DONE;
					if (changed)
					begin
						stored_mx <= scan_mx;
						deliv_mx <= scan_mx;
						if (deliver_now)
						begin
							// read out now, so nothing older may be replayed later
							delivered <= 1'b1;
							pending <= 1'b0;
							state <= ST_LOOKUP;
						end
						else
							pending <= 1'b1;
					end
				end
				ST_LOOKUP:
				begin
					if (lk_done)
						state <= ST_DONE;
				end
				ST_DONE:
				begin
					// record is already loaded, so done, update and record align
					scan_done <= 1'b1;
					scan_update <= delivered;
					state <= ST_IDLE;
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// flatten the buffered words into one pressed bit per key position
	genvar g;
	generate
		for (g = 0; g < NUM_KEYS; g++)
		begin : g_flat
			assign deliv_flat[g] = deliv_mx[g / NUM_COLS][g % NUM_COLS];
		end
	endgenerate

	kscan_keymap u_keymap
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(s_axi_awready && wr_map_hit && s_axi_wstrb[0]),
		.wr_addr(wr_map_off[7:2]),
		.wr_data(s_axi_wdata[7:0]),
		.rd_addr(lk_idx),
		.rd_data(map_code)
	);

	// lookup walk: one key position per cycle, keymap answers a cycle later
	assign lk_done = (state == ST_LOOKUP) && (lk_idx == KEY_IDX_END) && !lk_valid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || (state != ST_LOOKUP))
		begin
			lk_idx <= 6'h00;
			lk_valid <= 1'b0;
			lk_hit <= 1'b0;
		end
		else if (lk_idx != KEY_IDX_END)
		begin
			lk_idx <= lk_idx + 6'h01;
			lk_valid <= 1'b1;
			lk_hit <= deliv_flat[lk_idx];
		end
		else
			lk_valid <= 1'b0;
	end

	// record assembly; count and modifier restart with every pass
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rec_cnt <= 3'h0;
			rec_mod <= 8'h00;
			for (int k = 0; k < MAX_REPORTED_KEYS; k++)
				rec_codes[k] <= 8'h00;
		end
		else if (state != ST_LOOKUP)
		begin
			// keycode bytes stay as they were; stale ones lie past the count
			rec_cnt <= 3'h0;
			rec_mod <= 8'h00;
		end
		else if (lk_valid && lk_hit)
		begin
			// modifier codes should never be mapped; if they are, set their bit in the modifier byte
			if ((map_code >= MOD_CODE_LO) && (map_code <= MOD_CODE_HI))
				rec_mod[map_code[2:0]] <= 1'b1;
			else if (rec_cnt < MAX_REPORTED_KEYS)
			begin
				rec_codes[rec_cnt] <= map_code;
				rec_cnt <= rec_cnt + 3'h1;
			end
		end
	end

	// published record: byte 0 count, byte 1 modifier, bytes 2..7 keycodes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			key_event_record <= 64'h0000_0000_0000_0000;
			update_seen <= 1'b0;
		end
		else if (lk_done)
		begin
			key_event_record <= {rec_codes[5], rec_codes[4], rec_codes[3], rec_codes[2],
				rec_codes[1], rec_codes[0], rec_mod, 5'h00, rec_cnt};
			update_seen <= 1'b1;
		end
		else if (start_pulse && (state == ST_IDLE))
			update_seen <= 1'b0;
	end

endmodule // kscan_top

// File: sim/kscan_top_sva.sv
// port assertions for the key matrix scanner
// assumes binding to kscan_top, one clock, synchronous active-low reset
`timescale 1ns/1ns
module kscan_top_sva
	import kscan_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [NUM_ROWS-1:0] row_level,
	input wire logic scan_done,
	input wire logic scan_update,
	input wire logic [63:0] key_event_record
);
	localparam int min_hold = SETTLE_CYC - 1;
	logic [NUM_ROWS-1:0] row_q;
	logic [9:0] hold_cnt;

	// cycles the row drive has stood still; saturates so it never wraps
	always_ff @(posedge aclk)
	begin
		row_q <= row_level;
		if (!aresetn || row_level != row_q)
			hold_cnt <= 10'h000;
		else if (hold_cnt != 10'h3ff)
			hold_cnt <= hold_cnt + 10'h001;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_done_pulse;
		scan_done ##1 !scan_done;
	endsequence

	a_update_pairs: assert property (scan_update |-> s_done_pulse)
		else $error("update without a single done pulse");
	a_done_idle: assert property (scan_done |-> row_level == '1)
		else $error("rows still driven at pass end");
	a_count_cap: assert property (scan_update |-> key_event_record[7:0] <= 8'h06)
		else $error("key count above six");
	a_record_hold: assert property ($changed(key_event_record) |=> scan_done)
		else $error("record changed away from pass end");
	a_row_shape: assert property (row_level == '1 || row_level == '0 || $onehot(~row_level))
		else $error("more than one row driven outside the probe");
	a_probe_first: assert property (row_level != row_q && row_q == '1 |-> row_level == '0)
		else $error("pass did not open with a full probe");
	a_row_order: assert property (row_level != row_q && row_q != '1 |-> (row_q == '0
		? (row_level == '1 || ~row_level == NUM_ROWS'(1)) : ~row_level == NUM_ROWS'(~row_q << 1)))
		else $error("row walk out of order");
	a_settle_wait: assert property (row_level != row_q && row_q != '1 |-> hold_cnt >= 10'(min_hold))
		else $error("row drive changed before settle time");
endmodule // kscan_top_sva

bind kscan_top kscan_top_sva u_sva (.aclk(aclk), .aresetn(aresetn), .row_level(row_level),
	.scan_done(scan_done), .scan_update(scan_update), .key_event_record(key_event_record));

// File: sim/kscan_switch_matrix.sv
// behavioural switch matrix on the drive rows and sense columns
// assumes columns pulled up, rows active low, key index row*8+col
`timescale 1ns/1ns
module kscan_switch_matrix
	import kscan_pkg::*;
(
	input wire logic [NUM_ROWS-1:0] row_level,
	input wire logic [NUM_KEYS-1:0] pressed,
	output logic [NUM_COLS-1:0] col_level
);
	// a column only drops through a closed switch on a driven row; pull-up otherwise
	always_comb
	begin
		col_level = '1;
		for (int r = 0; r < NUM_ROWS; r++)
			for (int c = 0; c < NUM_COLS; c++)
				if (!row_level[r] && pressed[r*NUM_COLS+c])
					col_level[c] = 1'b0;
	end
endmodule // kscan_switch_matrix

// File: sim/tb_key_matrix_scanner.sv
// self-checking bench for the key matrix scanner
// assumes the switch matrix model on rows and columns, axi4-lite master here
`timescale 1ns/1ns
module tb_key_matrix_scanner import kscan_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [2:0] s_axi_awprot = 3'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [2:0] s_axi_arprot = 3'h0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic [NUM_COLS-1:0] col_level;
	logic [NUM_ROWS-1:0] row_level;
	logic scan_done;
	logic scan_update;
	logic [63:0] key_event_record;
	logic [NUM_KEYS-1:0] pressed = '0;
	logic [NUM_KEYS-1:0] stored = '0;
	logic [NUM_KEYS-1:0] prev = '0;
	logic [7:0] keymap [NUM_KEYS];
	logic [63:0] exp_rec = '0;
	logic [NUM_KEYS-1:0] held [$];
	logic [NUM_KEYS-1:0] keys_q = '0;
	int hold = 0;
	int n_mismatch = 0;
	int samples_checked = 0;

	kscan_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .col_level, .row_level, .scan_done, .scan_update, .key_event_record);
	kscan_switch_matrix u_keys (.row_level, .pressed(keys_q), .col_level);

	// the key pattern reaches the pins only at a clock edge, like any other stimulus
	always @(posedge aclk)
		keys_q <= pressed;

	// 20 MHz clock
	always #25 aclk = ~aclk;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic give_up();
		n_mismatch++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		complete_run();
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// master holds each channel until its ready; response ready stays up until answered
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
				break;
		end
		if (n == 50)
			give_up();
		check(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic reg_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
				break;
		end
		if (n == 50)
			give_up();
		check(s_axi_rresp, er);
		if (er == RESP_OKAY)
			check(s_axi_rdata, ed);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	// first six pressed keys in index order; later keycode bytes keep old contents
	function automatic logic [63:0] make_record(input logic [NUM_KEYS-1:0] mx, input logic [63:0] old);
		logic [63:0] r;
		int n;
		r = old;
		n = 0;
		for (int k = 0; k < NUM_KEYS; k++)
			if (mx[k] && n < 6)
			begin
				r[16+8*n +: 8] = keymap[k];
				n++;
			end
		r[15:0] = {8'h00, 8'(n)};
		return r;
	endfunction

	// one start (or a bare delivery when go is 0), model first, then compare at pass end
	task automatic run_pass(input logic fast, input logic dlv, input logic go, input logic twice);
		logic walk;
		logic upd;
		logic [63:0] m;
		logic [NUM_KEYS-1:0] dl;
		int n;
		walk = go && (pressed != '0 || hold > 0);
		upd = 1'b0;
		dl = stored;
		if (walk)
		begin
			if (fast ? pressed != stored : pressed == prev && pressed != stored)
			begin
				stored = pressed;
				dl = pressed;
				upd = dlv;
				// a newer state replaces whatever was still buffered
				held.delete();
				if (!dlv)
					held.push_back(pressed);
			end
			prev = pressed;
			hold = (pressed != '0) ? 6 : hold - 1;
		end
		if (!go && held.size() != 0)
		begin
			upd = 1'b1;
			dl = held.pop_front();
		end
		if (upd)
			exp_rec = make_record(dl, exp_rec);
		axi_write(OFF_CTRL, {29'h0, dlv, fast, go}, RESP_OKAY);
		if (twice)
			axi_write(OFF_CTRL, {29'h0, dlv, fast, go}, RESP_OKAY);
		for (n = 0; n < 4000 && scan_done !== 1'b1; n++)
			@(posedge aclk);
		if (n == 4000)
			give_up();
		check(scan_update, upd);
		check(n > 1000, walk);
		m = 64'hffff;
		for (int i = 0; i < 6; i++)
			if (i < exp_rec[7:0])
				m[16+8*i +: 8] = 8'hff;
		if (upd)
			check(key_event_record & m, exp_rec & m);
		// stale keycode bytes past the count must still hold their old contents
		if (upd)
			check(key_event_record, exp_rec);
		$display("pass ended: update %0b after %0d cycles", scan_update, n);
		// a start taken while busy would have the rows moving again by now
		if (twice)
		begin
			repeat (450) @(posedge aclk);
			check(row_level === '1, 1'b1);
		end
	endtask

	// main sequence
	initial
	begin
		void'($urandom(5));
		repeat (12) @(posedge aclk);
		check(key_event_record, 64'h0);
		check(row_level === '1, 1'b1);
		aresetn <= 1'b1;
		@(posedge aclk);
		reg_read(OFF_CTRL, 32'h4, RESP_OKAY);
		reg_read(OFF_MATRIX, 32'h0, RESP_OKAY);
		reg_read(12'h0fc, 32'h0, RESP_SLVERR);
		axi_write(12'h0fc, 32'h1, RESP_SLVERR);
		// modifier window codes stay out of the keymap
		for (int k = 0; k < NUM_KEYS; k++)
		begin
			keymap[k] = 8'($urandom_range(8'hdf, 8'h01));
			axi_write(OFF_KEYMAP + 12'(4 * k), {24'h0, keymap[k]}, RESP_OKAY);
		end
		run_pass(1'b0, 1'b1, 1'b1, 1'b0);
		for (int s = 0; s < 10; s++)
		begin
			case (s)
				0: pressed = 40'h1;
				1: pressed = 40'h80_0000_0001;
				2: pressed = 40'h81_4221_0883;
				3: pressed = '0;
				default: pressed = {8'($urandom), $urandom} & {8'($urandom), $urandom};
			endcase
			run_pass(1'b0, 1'b1, 1'b1, s == 2);
			if (s < 4 || $urandom_range(3, 0) != 0)
				run_pass(1'b0, 1'b1, 1'b1, 1'b0);
		end
		pressed = '0;
		repeat (8) run_pass(1'b0, 1'b1, 1'b1, 1'b0);
		pressed = 40'h20;
		run_pass(1'b1, 1'b1, 1'b1, 1'b0);
		pressed = 40'h60;
		run_pass(1'b0, 1'b0, 1'b1, 1'b0);
		run_pass(1'b0, 1'b0, 1'b1, 1'b0);
		reg_read(OFF_STATUS, 32'h4, RESP_OKAY);
		run_pass(1'b0, 1'b1, 1'b0, 1'b0);
		for (int r = 0; r < NUM_ROWS; r++)
			reg_read(OFF_MATRIX + 12'(4 * r), {24'h0, stored[r*NUM_COLS +: 8]},
				RESP_OKAY);
		complete_run();
	end
endmodule // tb_key_matrix_scanner
